/* ssr_pkg.sv */
`default_nettype none
package ssr_pkg;
   // register sets reachable through the query port
   localparam logic [2:0] SET_MEAS  = 3'h0;
   localparam logic [2:0] SET_SENSE = 3'h1;
   localparam logic [2:0] SET_TRIG  = 3'h2;
   localparam logic [2:0] SET_ULF   = 3'h3;
   localparam logic [2:0] SET_QUES  = 3'h4;
   localparam logic [2:0] SET_CAL   = 3'h5;
   localparam logic [2:0] SET_POW   = 3'h6;
   localparam int         NUM_SETS  = 7;

   // register within a set
   localparam logic [2:0] REG_COND  = 3'h0;
   localparam logic [2:0] REG_EVENT = 3'h1;
   localparam logic [2:0] REG_ENAB  = 3'h2;
   localparam logic [2:0] REG_PTR   = 3'h3;
   localparam logic [2:0] REG_NTR   = 3'h4;

   localparam int REG_W = 15;

   // field positions
   localparam int BIT_STATUS   = 1;
   localparam int BIT_CALC_LO  = 3;
   localparam int BIT_Q_POWER  = 3;
   localparam int BIT_Q_CAL    = 8;
   localparam int BIT_Q_SELFT  = 9;

   // preset and reset values of the filters
   localparam logic [14:0] ENAB_ONES  = 15'h7FFF;
   localparam logic [14:0] ENAB_ZEROS = 15'h0000;
   localparam logic [14:0] PTR_PRESET = 15'h7FFF;
   localparam logic [14:0] NTR_PRESET = 15'h0000;

   // error queue
   localparam int          ERRQ_DEPTH = 30;
   localparam int          ERR_CODE_W = 16;
   localparam int          ERR_MSG_W  = 8;
   localparam logic [15:0] ERR_NONE      = 16'h0000;
   localparam logic [15:0] ERR_OVERFLOW  = 16'hFEA2;
   localparam logic [7:0]  MSG_NO_ERROR  = 8'h00;
   localparam logic [7:0]  MSG_OVERFLOW  = 8'h01;
endpackage : ssr_pkg
`default_nettype wire

/* ssr_reg_set.sv */
`default_nettype none
module ssr_reg_set #(
   parameter logic [14:0] PRESET_EN = ssr_pkg::ENAB_ONES
) (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // condition source
   input  wire logic [14:0] cond_i,
   // software access
   input  wire logic        wr_enab_i,
   input  wire logic        wr_ptr_i,
   input  wire logic        wr_ntr_i,
   input  wire logic [14:0] wdata_i,
   input  wire logic        ev_rd_i,
   input  wire logic        preset_i,
   // state
   output logic      [14:0] cond_o,
   output logic      [14:0] event_o,
   output logic      [14:0] enab_o,
   output logic      [14:0] ptr_o,
   output logic      [14:0] ntr_o,
   output logic             summary_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   logic [14:0] cond_q;
   logic [14:0] event_q;
   logic [14:0] enab_q;
   logic [14:0] ptr_q;
   logic [14:0] ntr_q;
   logic [14:0] latch_vec;

   assign latch_vec = (cond_i & ~cond_q & ptr_q) | (~cond_i & cond_q & ntr_q);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cond_q <= '0;
      end else begin
         cond_q <= cond_i;
      end
   end

   // a new edge in the read cycle survives the clear
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         event_q <= '0;
      end else begin
         event_q <= (ev_rd_i ? 15'h0000 : event_q) | latch_vec;
      end
   end

   // preset beats a write in the same cycle
   always_ff @(posedge sys_clk_i) begin
      if (rst_i || preset_i) begin
         enab_q <= PRESET_EN;
         ptr_q  <= ssr_pkg::PTR_PRESET;
         ntr_q  <= ssr_pkg::NTR_PRESET;
      end else begin
         if (wr_enab_i) begin
            enab_q <= wdata_i;
         end
         if (wr_ptr_i) begin
            ptr_q <= wdata_i;
         end
         if (wr_ntr_i) begin
            ntr_q <= wdata_i;
         end
      end
   end

   assign cond_o    = cond_q;
   assign event_o   = event_q;
   assign enab_o    = enab_q;
   assign ptr_o     = ptr_q;
   assign ntr_o     = ntr_q;
   assign summary_o = |(event_q & enab_q);

   a_preset_filters: assert property (preset_i |=> enab_q == PRESET_EN
      && ptr_q == ssr_pkg::PTR_PRESET && ntr_q == ssr_pkg::NTR_PRESET)
      else $error("preset values not applied");
   a_event_read_clear: assert property (ev_rd_i |=> (event_q & ~$past(latch_vec)) == 15'h0000)
      else $error("event register not cleared by read");
   a_event_rise_latch: assert property ((latch_vec != 15'h0000) |=>
      (event_q & $past(latch_vec)) == $past(latch_vec))
      else $error("filtered edge not latched");
endmodule : ssr_reg_set
`default_nettype wire

/* ssr_status_top.sv */
`default_nettype none
module ssr_status_top #(
   parameter int ERRQ_DEPTH = ssr_pkg::ERRQ_DEPTH
) (
   // clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   // command and query port
   input  wire logic        cmd_valid_i,
   input  wire logic        cmd_write_i,
   input  wire logic [2:0]  cmd_set_i,
   input  wire logic [2:0]  cmd_reg_i,
   input  wire logic [15:0] cmd_wdata_i,
   input  wire logic        preset_i,
   input  wire logic        clear_status_i,
   output logic             rsp_valid_o,
   output logic      [15:0] rsp_data_o,
   // activity sources
   input  wire logic        meas_active_i,
   input  wire logic        mem_reading_i,
   input  wire logic        trig_wait_enter_i,
   input  wire logic        acq_idle_enter_i,
   // limit and quality sources, index 0 sensing channel, 1..4 computation blocks
   input  wire logic        meas_done_i,
   input  wire logic [4:0]  ul_test_en_i,
   input  wire logic [4:0]  ul_fail_i,
   input  wire logic        overload_i,
   input  wire logic [3:0]  calc_err_i,
   input  wire logic        cal_done_i,
   input  wire logic        cal_err_i,
   input  wire logic        selftest_done_i,
   input  wire logic        selftest_pass_i,
   // error queue
   input  wire logic        err_push_i,
   input  wire logic [15:0] err_code_i,
   input  wire logic [7:0]  err_msg_i,
   input  wire logic        err_query_i,
   output logic             err_rsp_valid_o,
   output logic      [15:0] err_code_o,
   output logic      [7:0]  err_msg_o,
   output logic      [5:0]  err_count_o,
   // summaries toward the operation and top-level sets
   output logic      [3:0]  op_summary_o,
   output logic             ques_summary_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   // spreads five source bits over status bit 1 and bits 3..6
   function automatic logic [14:0] src_map(input logic [4:0] s);
      logic [14:0] v;
      v = 15'h0000;
      v[ssr_pkg::BIT_STATUS] = s[0];
      v[ssr_pkg::BIT_CALC_LO +: 4] = s[4:1];
      return v;
   endfunction : src_map

   function automatic logic [4:0] ptr_inc(input logic [4:0] p);
      return (p == 5'(ERRQ_DEPTH - 1)) ? 5'h00 : 5'(p + 5'h01);
   endfunction : ptr_inc

   function automatic logic [4:0] ptr_dec(input logic [4:0] p);
      return (p == 5'h00) ? 5'(ERRQ_DEPTH - 1) : 5'(p - 5'h01);
   endfunction : ptr_dec

   // ---------------- condition sources
   logic       trig_q;
   logic [4:0] ul_q;
   logic [4:0] pq_q;
   logic [4:0] pq_seen_q;
   logic [4:0] pq_src;
   logic       cal_q;
   logic       err_since_cal_q;
   logic       st_q;

   // set wins when wait and idle land together
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         trig_q <= 1'b0;
      end else if (trig_wait_enter_i) begin
         trig_q <= 1'b1;
      end else if (acq_idle_enter_i) begin
         trig_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ul_q <= '0;
      end else if (meas_done_i) begin
         ul_q <= (ul_q | (ul_test_en_i & ul_fail_i))
               & ~(ul_test_en_i & ~ul_fail_i);
      end
   end

   assign pq_src = {calc_err_i, overload_i};

   // errors during a measurement are kept when it completes; the next completion without them clears them
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         pq_q      <= '0;
         pq_seen_q <= '0;
      end else begin
         pq_q <= pq_src
               | (pq_q & ~(meas_done_i ? ~(pq_seen_q | pq_src) : 5'h00));
         pq_seen_q <= meas_done_i ? 5'h00 : (pq_seen_q | pq_src);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cal_q           <= 1'b0;
         err_since_cal_q <= 1'b0;
      end else begin
         if (cal_done_i && cal_err_i) begin
            cal_q <= 1'b1;
         end else if (cal_done_i && !err_since_cal_q && !err_push_i) begin
            cal_q <= 1'b0;
         end
         err_since_cal_q <= cal_done_i ? 1'b0 : (err_since_cal_q | err_push_i);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         st_q <= 1'b0;
      end else if (selftest_done_i) begin
         st_q <= !selftest_pass_i;
      end
   end

   // ---------------- register sets
   localparam int NUM_SETS_L = ssr_pkg::NUM_SETS;

   logic [14:0] cond_in [NUM_SETS_L];
   logic [14:0] cond_v  [NUM_SETS_L];
   logic [14:0] event_v [NUM_SETS_L];
   logic [14:0] enab_v  [NUM_SETS_L];
   logic [14:0] ptr_v   [NUM_SETS_L];
   logic [14:0] ntr_v   [NUM_SETS_L];
   logic [NUM_SETS_L-1:0] summ_v;

   logic cmd_rd;
   logic cmd_wr;
   assign cmd_rd = cmd_valid_i && !cmd_write_i;
   assign cmd_wr = cmd_valid_i && cmd_write_i;

   always_comb begin
      for (int i = 0; i < NUM_SETS_L; i++) begin
         cond_in[i] = 15'h0000;
      end
      cond_in[ssr_pkg::SET_MEAS][ssr_pkg::BIT_STATUS]  = meas_active_i;
      cond_in[ssr_pkg::SET_SENSE][ssr_pkg::BIT_STATUS] = mem_reading_i;
      cond_in[ssr_pkg::SET_TRIG][ssr_pkg::BIT_STATUS]  = trig_q;
      cond_in[ssr_pkg::SET_ULF]                        = src_map(ul_q);
      cond_in[ssr_pkg::SET_POW]                        = src_map(pq_q);
      cond_in[ssr_pkg::SET_CAL][ssr_pkg::BIT_STATUS]   = cal_q;
      cond_in[ssr_pkg::SET_QUES][ssr_pkg::BIT_Q_POWER] = summ_v[ssr_pkg::SET_POW];
      cond_in[ssr_pkg::SET_QUES][ssr_pkg::BIT_Q_CAL]   = summ_v[ssr_pkg::SET_CAL];
      cond_in[ssr_pkg::SET_QUES][ssr_pkg::BIT_Q_SELFT] = st_q;
   end

   for (genvar g = 0; g < NUM_SETS_L; g++) begin : g_set
      localparam logic [2:0] IDX = 3'(g);
      ssr_reg_set #(
         .PRESET_EN ((IDX == ssr_pkg::SET_QUES) ? ssr_pkg::ENAB_ZEROS : ssr_pkg::ENAB_ONES)
      ) u_set (
         .sys_clk_i (sys_clk_i),
         .rst_i     (rst_i),
         .cond_i    (cond_in[g]),
         .wr_enab_i (cmd_wr && cmd_set_i == IDX && cmd_reg_i == ssr_pkg::REG_ENAB),
         .wr_ptr_i  (cmd_wr && cmd_set_i == IDX && cmd_reg_i == ssr_pkg::REG_PTR),
         .wr_ntr_i  (cmd_wr && cmd_set_i == IDX && cmd_reg_i == ssr_pkg::REG_NTR),
         .wdata_i   (cmd_wdata_i[14:0]),
         .ev_rd_i   (cmd_rd && cmd_set_i == IDX && cmd_reg_i == ssr_pkg::REG_EVENT),
         .preset_i  (preset_i),
         .cond_o    (cond_v[g]),
         .event_o   (event_v[g]),
         .enab_o    (enab_v[g]),
         .ptr_o     (ptr_v[g]),
         .ntr_o     (ntr_v[g]),
         .summary_o (summ_v[g])
      );
   end

   // ---------------- query answers
   logic [14:0] rd_val;
   always_comb begin
      rd_val = 15'h0000;
      if (cmd_set_i < 3'(NUM_SETS_L)) begin
         unique case (cmd_reg_i)
            ssr_pkg::REG_COND:  rd_val = cond_v[cmd_set_i];
            ssr_pkg::REG_EVENT: rd_val = event_v[cmd_set_i];
            ssr_pkg::REG_ENAB:  rd_val = enab_v[cmd_set_i];
            ssr_pkg::REG_PTR:   rd_val = ptr_v[cmd_set_i];
            ssr_pkg::REG_NTR:   rd_val = ntr_v[cmd_set_i];
            default:            rd_val = 15'h0000;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         rsp_valid_o <= 1'b0;
         rsp_data_o  <= '0;
      end else begin
         rsp_valid_o <= cmd_rd;
         if (cmd_rd) begin
            rsp_data_o <= {1'b0, rd_val};
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         op_summary_o   <= '0;
         ques_summary_o <= 1'b0;
      end else begin
         op_summary_o <= {summ_v[ssr_pkg::SET_ULF], summ_v[ssr_pkg::SET_TRIG],
                          summ_v[ssr_pkg::SET_SENSE], summ_v[ssr_pkg::SET_MEAS]};
         ques_summary_o <= summ_v[ssr_pkg::SET_QUES];
      end
   end

   // ---------------- error queue
   // pointers are deliberately outside reset so a reset keeps queued errors;
   // they rely on the power-up value instead
   logic [15:0] q_code [ERRQ_DEPTH];
   logic [7:0]  q_msg  [ERRQ_DEPTH];
   logic [4:0]  rd_ptr_q = 5'h00;
   logic [4:0]  wr_ptr_q = 5'h00;
   logic [5:0]  count_q  = 6'h00;
   logic        pop_ok;
   logic        q_full;
   logic        push_ok;
   logic        push_ovf;

   assign q_full   = (count_q == 6'(ERRQ_DEPTH));
   assign pop_ok   = err_query_i && (count_q != 6'h00) && !clear_status_i;
   assign push_ok  = err_push_i && (!q_full || pop_ok || clear_status_i);
   assign push_ovf = err_push_i && q_full && !pop_ok && !clear_status_i;

   // clear-status discards old entries; a push in the same cycle is kept
   always_ff @(posedge sys_clk_i) begin
      if (clear_status_i) begin
         rd_ptr_q <= 5'h00;
         wr_ptr_q <= push_ok ? 5'h01 : 5'h00;
         count_q  <= push_ok ? 6'h01 : 6'h00;
      end else begin
         if (pop_ok) begin
            rd_ptr_q <= ptr_inc(rd_ptr_q);
         end
         if (push_ok) begin
            wr_ptr_q <= ptr_inc(wr_ptr_q);
         end
         count_q <= 6'(count_q + 6'(push_ok) - 6'(pop_ok));
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (push_ok) begin
         q_code[clear_status_i ? 5'h00 : wr_ptr_q] <= err_code_i;
         q_msg[clear_status_i ? 5'h00 : wr_ptr_q]  <= err_msg_i;
      end else if (push_ovf) begin
         q_code[ptr_dec(wr_ptr_q)] <= ssr_pkg::ERR_OVERFLOW;
         q_msg[ptr_dec(wr_ptr_q)]  <= ssr_pkg::MSG_OVERFLOW;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         err_rsp_valid_o <= 1'b0;
         err_code_o      <= ssr_pkg::ERR_NONE;
         err_msg_o       <= ssr_pkg::MSG_NO_ERROR;
         err_count_o     <= '0;
      end else begin
         err_rsp_valid_o <= err_query_i;
         err_count_o     <= count_q;
         if (pop_ok) begin
            err_code_o <= q_code[rd_ptr_q];
            err_msg_o  <= q_msg[rd_ptr_q];
         end else if (err_query_i) begin
            err_code_o <= ssr_pkg::ERR_NONE;
            err_msg_o  <= ssr_pkg::MSG_NO_ERROR;
         end
      end
   end

   // ---------------- checks
   sequence s_wait_entered;
      trig_wait_enter_i ##1 trig_q;
   endsequence

   sequence s_ul_failed;
      meas_done_i && ul_test_en_i[0] && ul_fail_i[0];
   endsequence

   a_meas_cond_track: assert property ($changed(meas_active_i) |=>
      g_set[0].u_set.cond_o[ssr_pkg::BIT_STATUS] == $past(meas_active_i))
      else $error("measuring bit does not follow activity");
   a_mem_read_track: assert property (
      g_set[1].u_set.cond_o[ssr_pkg::BIT_STATUS] == $past(mem_reading_i))
      else $error("memory read bit does not follow reading");
   a_trig_wait_set: assert property (s_wait_entered |=>
      g_set[2].u_set.cond_o[ssr_pkg::BIT_STATUS])
      else $error("trigger wait bit not set");
   a_ul_fail_set: assert property (s_ul_failed |=> ul_q[0])
      else $error("upper limit failure not latched");
   a_ul_pass_clear: assert property (meas_done_i && ul_test_en_i[2] && !ul_fail_i[2]
      |=> !ul_q[2])
      else $error("upper limit bit not cleared on pass");
   a_bit15_zero: assert property (rsp_valid_o |-> !rsp_data_o[15])
      else $error("bit 15 read as one");
   a_power_quality_set_sum: assert property (
      g_set[4].u_set.cond_o[ssr_pkg::BIT_Q_POWER] == $past(summ_v[ssr_pkg::SET_POW]))
      else $error("power summary not reflected");
   a_ques_cal_sum: assert property (
      g_set[4].u_set.cond_o[ssr_pkg::BIT_Q_CAL] == $past(summ_v[ssr_pkg::SET_CAL]))
      else $error("calibration summary not reflected");
   a_selftest_fail: assert property (selftest_done_i && !selftest_pass_i |=> st_q ##1
      g_set[4].u_set.cond_o[ssr_pkg::BIT_Q_SELFT])
      else $error("self-test failure not shown");
   a_overload_set: assert property (overload_i |=> pq_q[0])
      else $error("overload not latched");
   a_empty_query: assert property (err_query_i && count_q == 6'h00 && !err_push_i
      |=> err_rsp_valid_o && err_code_o == ssr_pkg::ERR_NONE && count_q == 6'h00)
      else $error("empty queue query wrong");
   a_queue_limit: assert property (count_q <= 6'(ERRQ_DEPTH))
      else $error("queue beyond capacity");
   a_cls_empty: assert property (clear_status_i && !err_push_i |=> count_q == 6'h00)
      else $error("queue not emptied");
   a_overflow_code: assert property (push_ovf |=> q_full
      && q_code[ptr_dec(wr_ptr_q)] == ssr_pkg::ERR_OVERFLOW)
      else $error("overflow code not stored");
endmodule : ssr_status_top
`default_nettype wire

/* ssr_host_model.sv */
`default_nettype none
module ssr_host_model (
   // clock
   input  wire logic        sys_clk_i,
   // register port
   output logic             cmd_valid_o,
   output logic             cmd_write_o,
   output logic      [2:0]  cmd_set_o,
   output logic      [2:0]  cmd_reg_o,
   output logic      [15:0] cmd_wdata_o,
   output logic             preset_o,
   output logic             clear_status_o,
   input  wire logic        rsp_valid_i,
   input  wire logic [15:0] rsp_data_i,
   // error queue
   output logic             err_push_o,
   output logic      [15:0] err_code_o,
   output logic      [7:0]  err_msg_o,
   output logic             err_query_o,
   input  wire logic        err_rsp_valid_i,
   input  wire logic [15:0] err_code_i,
   input  wire logic [7:0]  err_msg_i
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {cmd_valid_o, cmd_write_o, cmd_set_o, cmd_reg_o, cmd_wdata_o} = '0;
      {preset_o, clear_status_o, err_push_o, err_code_o, err_msg_o, err_query_o} = '0;
   end

   // a missing answer turns into unknown so it can never match
   task reg_acc(input logic wr, input logic [2:0] s, input logic [2:0] r,
                input logic [15:0] wd, output logic [15:0] rd);
      @(negedge sys_clk_i);
      {cmd_valid_o, cmd_write_o, cmd_set_o, cmd_reg_o, cmd_wdata_o} = {1'b1, wr, s, r, wd};
      @(negedge sys_clk_i);
      rd = (!wr && rsp_valid_i === 1'b1) ? rsp_data_i : 16'hXXXX;
      cmd_valid_o = 1'b0;
   endtask : reg_acc

   // clr 0 preset, 1 clear-status
   task pulse(input logic clr);
      @(negedge sys_clk_i);
      {preset_o, clear_status_o} = clr ? 2'h1 : 2'h2;
      @(negedge sys_clk_i);
      {preset_o, clear_status_o} = 2'h0;
   endtask : pulse

   task err_put(input logic [15:0] code, input logic [7:0] msg);
      @(negedge sys_clk_i);
      {err_push_o, err_code_o, err_msg_o} = {1'b1, code, msg};
      @(negedge sys_clk_i);
      err_push_o = 1'b0;
   endtask : err_put

   task err_get(output logic [15:0] code, output logic [7:0] msg);
      @(negedge sys_clk_i);
      err_query_o = 1'b1;
      @(negedge sys_clk_i);
      code = (err_rsp_valid_i === 1'b1) ? err_code_i : 16'hXXXX;
      msg  = err_msg_i;
      err_query_o = 1'b0;
   endtask : err_get
endmodule : ssr_host_model
`default_nettype wire

/* test_ssr_status_top.sv */
`default_nettype none
module test_ssr_status_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DEPTH = 30;
   typedef struct packed {
      logic        wr;
      logic [2:0]  s;
      logic [2:0]  r;
      logic [15:0] wd;
      logic [15:0] ex;
   } ssr_row_t;

   logic        sys_clk_i, rst_i, cmd_valid_i, cmd_write_i, preset_i, clear_status_i;
   logic [2:0]  cmd_set_i, cmd_reg_i;
   logic [15:0] cmd_wdata_i, rsp_data_o, err_code_i, err_code_o, d, c;
   logic        rsp_valid_o, meas_active_i, mem_reading_i, trig_wait_enter_i, acq_idle_enter_i;
   logic        meas_done_i, overload_i, cal_done_i, cal_err_i, selftest_done_i, selftest_pass_i;
   logic [4:0]  ul_test_en_i, ul_fail_i;
   logic [3:0]  calc_err_i, op_summary_o;
   logic        err_push_i, err_query_i, err_rsp_valid_o, ques_summary_o;
   logic [7:0]  err_msg_i, err_msg_o, m;
   logic [5:0]  err_count_o;
   int          num_errors = 0, cmp_count = 0, cycles = 0;
   ssr_row_t    rows [9] = '{
      '{1'b0, ssr_pkg::SET_MEAS, ssr_pkg::REG_ENAB, 16'h0000, 16'h7FFF},
      '{1'b0, ssr_pkg::SET_QUES, ssr_pkg::REG_ENAB, 16'h0000, 16'h0000},
      '{1'b0, ssr_pkg::SET_POW, ssr_pkg::REG_PTR, 16'h0000, 16'h7FFF},
      '{1'b0, ssr_pkg::SET_CAL, ssr_pkg::REG_COND, 16'h0000, 16'h0000},
      '{1'b1, ssr_pkg::SET_TRIG, ssr_pkg::REG_ENAB, 16'h8001, 16'h0001},
      '{1'b1, ssr_pkg::SET_ULF, ssr_pkg::REG_NTR, 16'h8005, 16'h0005},
      '{1'b1, ssr_pkg::SET_QUES, ssr_pkg::REG_ENAB, 16'h8300, 16'h0300},
      '{1'b1, ssr_pkg::SET_CAL, ssr_pkg::REG_COND, 16'h1234, 16'h0000},
      '{1'b0, 3'h7, ssr_pkg::REG_COND, 16'h0000, 16'h0000}};

   ssr_status_top #(.ERRQ_DEPTH(DEPTH)) DUT (
      .sys_clk_i, .rst_i, .cmd_valid_i, .cmd_write_i, .cmd_set_i, .cmd_reg_i, .cmd_wdata_i,
      .preset_i, .clear_status_i, .rsp_valid_o, .rsp_data_o, .meas_active_i, .mem_reading_i,
      .trig_wait_enter_i, .acq_idle_enter_i, .meas_done_i, .ul_test_en_i, .ul_fail_i,
      .overload_i, .calc_err_i, .cal_done_i, .cal_err_i, .selftest_done_i, .selftest_pass_i,
      .err_push_i, .err_code_i, .err_msg_i, .err_query_i, .err_rsp_valid_o, .err_code_o,
      .err_msg_o, .err_count_o, .op_summary_o, .ques_summary_o);

   ssr_host_model host (
      .sys_clk_i, .cmd_valid_o(cmd_valid_i), .cmd_write_o(cmd_write_i), .cmd_set_o(cmd_set_i),
      .cmd_reg_o(cmd_reg_i), .cmd_wdata_o(cmd_wdata_i), .preset_o(preset_i),
      .clear_status_o(clear_status_i), .rsp_valid_i(rsp_valid_o), .rsp_data_i(rsp_data_o),
      .err_push_o(err_push_i), .err_code_o(err_code_i), .err_msg_o(err_msg_i),
      .err_query_o(err_query_i), .err_rsp_valid_i(err_rsp_valid_o), .err_code_i(err_code_o),
      .err_msg_i(err_msg_o));

   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end

   task report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop

   // a hang counts as a mismatch
   always @(posedge sys_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         report_and_stop;
      end
   end

   task chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
      cmp_count++;
      if (got !== ex) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, ex, got);
      end
   endtask : chk

   task rdc(input logic [2:0] s, input logic [2:0] r, input logic [15:0] ex);
      host.reg_acc(1'b0, s, r, 16'h0000, d);
      chk($sformatf("set %0d reg %0d", s, r), ex, d);
   endtask : rdc

   task cyc(input int n);
      repeat (n) @(negedge sys_clk_i);
   endtask : cyc

   initial begin
      rst_i = 1'b1;
      {meas_active_i, mem_reading_i, trig_wait_enter_i, acq_idle_enter_i, meas_done_i} = '0;
      {ul_test_en_i, ul_fail_i, overload_i, calc_err_i, cal_done_i, cal_err_i} = '0;
      {selftest_done_i, selftest_pass_i} = '0;
      cyc(10);
      rst_i = 1'b0;
      foreach (rows[i]) begin
         if (rows[i].wr) host.reg_acc(1'b1, rows[i].s, rows[i].r, rows[i].wd, d);
         rdc(rows[i].s, rows[i].r, rows[i].ex);
      end
      host.pulse(1'b0);
      rdc(ssr_pkg::SET_TRIG, ssr_pkg::REG_ENAB, 16'h7FFF);
      rdc(ssr_pkg::SET_ULF, ssr_pkg::REG_NTR, 16'h0000);
      rdc(ssr_pkg::SET_QUES, ssr_pkg::REG_ENAB, 16'h0000);
      meas_active_i = 1'b1;
      cyc(3);
      rdc(ssr_pkg::SET_MEAS, ssr_pkg::REG_COND, 16'h0002);
      rdc(ssr_pkg::SET_MEAS, ssr_pkg::REG_EVENT, 16'h0002);
      rdc(ssr_pkg::SET_MEAS, ssr_pkg::REG_EVENT, 16'h0000);
      meas_active_i = 1'b0;
      mem_reading_i = 1'b1;
      trig_wait_enter_i = 1'b1;
      cyc(1);
      trig_wait_enter_i = 1'b0;
      cyc(3);
      rdc(ssr_pkg::SET_MEAS, ssr_pkg::REG_COND, 16'h0000);
      rdc(ssr_pkg::SET_SENSE, ssr_pkg::REG_COND, 16'h0002);
      rdc(ssr_pkg::SET_TRIG, ssr_pkg::REG_COND, 16'h0002);
      mem_reading_i = 1'b0;
      acq_idle_enter_i = 1'b1;
      cyc(1);
      acq_idle_enter_i = 1'b0;
      cyc(3);
      rdc(ssr_pkg::SET_SENSE, ssr_pkg::REG_COND, 16'h0000);
      rdc(ssr_pkg::SET_TRIG, ssr_pkg::REG_COND, 16'h0000);
      {ul_test_en_i, ul_fail_i, meas_done_i} = {5'h1F, 5'h03, 1'b1};
      cyc(1);
      {ul_test_en_i, ul_fail_i, meas_done_i} = {5'h01, 5'h04, 1'b0};
      cyc(3);
      rdc(ssr_pkg::SET_ULF, ssr_pkg::REG_COND, 16'h000A);
      // meas event cleared by read, falling edges filtered out
      chk("op summary", 16'h000E, {12'h000, op_summary_o});
      meas_done_i = 1'b1;
      cyc(1);
      {ul_test_en_i, ul_fail_i, meas_done_i} = '0;
      {overload_i, calc_err_i} = {1'b1, 4'h8};
      cyc(1);
      {overload_i, calc_err_i} = '0;
      cyc(3);
      rdc(ssr_pkg::SET_ULF, ssr_pkg::REG_COND, 16'h0008);
      rdc(ssr_pkg::SET_POW, ssr_pkg::REG_COND, 16'h0042);
      rdc(ssr_pkg::SET_QUES, ssr_pkg::REG_COND, 16'h0008);
      // the measurement that saw the errors keeps them; the next clean one clears
      meas_done_i = 1'b1;
      cyc(1);
      meas_done_i = 1'b0;
      cyc(3);
      rdc(ssr_pkg::SET_POW, ssr_pkg::REG_COND, 16'h0042);
      meas_done_i = 1'b1;
      cyc(1);
      meas_done_i = 1'b0;
      cyc(3);
      rdc(ssr_pkg::SET_POW, ssr_pkg::REG_COND, 16'h0000);
      rdc(ssr_pkg::SET_POW, ssr_pkg::REG_EVENT, 16'h0042);
      {cal_done_i, cal_err_i} = 2'h3;
      cyc(1);
      {cal_done_i, cal_err_i} = 2'h0;
      cyc(4);
      rdc(ssr_pkg::SET_CAL, ssr_pkg::REG_COND, 16'h0002);
      rdc(ssr_pkg::SET_QUES, ssr_pkg::REG_COND, 16'h0100);
      host.reg_acc(1'b1, ssr_pkg::SET_QUES, ssr_pkg::REG_ENAB, 16'h0200, d);
      {cal_done_i, selftest_done_i} = 2'h3;
      cyc(1);
      {cal_done_i, selftest_done_i} = 2'h0;
      cyc(4);
      rdc(ssr_pkg::SET_CAL, ssr_pkg::REG_COND, 16'h0000);
      rdc(ssr_pkg::SET_QUES, ssr_pkg::REG_COND, 16'h0300);
      chk("ques summary", 16'h0001, {15'h0000, ques_summary_o});
      {selftest_done_i, selftest_pass_i} = 2'h3;
      cyc(1);
      {selftest_done_i, selftest_pass_i} = 2'h0;
      cyc(4);
      rdc(ssr_pkg::SET_QUES, ssr_pkg::REG_COND, 16'h0100);
      host.err_get(c, m);
      chk("empty code", ssr_pkg::ERR_NONE, c);
      for (int i = 1; i <= DEPTH + 1; i++) host.err_put(i[15:0], 8'h07);
      cyc(2);
      chk("count", DEPTH[15:0], {10'h000, err_count_o});
      for (int i = 1; i <= DEPTH; i++) begin
         host.err_get(c, m);
         chk("queue code", (i == DEPTH) ? ssr_pkg::ERR_OVERFLOW : i[15:0], c);
      end
      chk("overflow msg", {8'h00, ssr_pkg::MSG_OVERFLOW}, {8'h00, m});
      host.err_put(16'hFF19, 8'h03);
      host.err_put(16'hFF1A, 8'h04);
      host.pulse(1'b1);
      host.err_get(c, m);
      chk("cleared code", ssr_pkg::ERR_NONE, c);
      host.err_put(16'hFF18, 8'h02);
      rst_i = 1'b1;
      cyc(2);
      rst_i = 1'b0;
      host.err_get(c, m);
      chk("kept code", 16'hFF18, c);
      report_and_stop;
   end
endmodule : test_ssr_status_top
`default_nettype wire
